/* common/stp_pkg.sv */
// Package for the spanning tree port state control block
package stp_pkg;
  // AXI4-Lite register map: byte address is four times the register index
  localparam logic [7:0] STP_P1_CTRL_IDX  = 8'd18;
  localparam logic [7:0] STP_P2_CTRL_IDX  = 8'd34;
  localparam logic [7:0] STP_FLUSH_IDX    = 8'd2;
  localparam logic [9:0] STP_P1_CTRL_ADDR = {STP_P1_CTRL_IDX, 2'b00};
  localparam logic [9:0] STP_P2_CTRL_ADDR = {STP_P2_CTRL_IDX, 2'b00};
  localparam logic [9:0] STP_FLUSH_ADDR   = {STP_FLUSH_IDX, 2'b00};
  localparam logic [9:0] STP_STATUS_ADDR  = 10'h100;
  // Port control fields
  localparam int STP_LRN_DIS_BIT = 0;
  localparam int STP_RX_EN_BIT   = 1;
  localparam int STP_TX_EN_BIT   = 2;
  // Flush register fields
  localparam int STP_FLUSH_STA_BIT = 4;
  localparam int STP_FLUSH_DYN_BIT = 5;
  // Reset: forwarding (tx 1, rx 1, learn disable 0)
  localparam logic [2:0] STP_CTRL_RST = 3'h6;
  localparam logic [1:0] STP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] STP_RESP_SLVERR = 2'h2;
  typedef enum logic [4:0] {
    STP_DISABLED   = 5'h01,
    STP_BLOCKING   = 5'h02,
    STP_LEARNING   = 5'h04,
    STP_FORWARDING = 5'h08,
    STP_ODD        = 5'h10
  } stp_state_t;
endpackage

/* hdl/stp_port_ctrl.sv */
// Spanning tree port state control with AXI4-Lite registers
`timescale 1ns/10ps
// Notes on behaviour
// [R1] Port 3 is the processor port; state control covers only ports 1 and 2.
// [R2] Ports 1 and 2 each hold tx enable, rx enable, learn disable controls.
// [R3] Tx 0, rx 0, learn disable 1: no user traffic, no learning.
// [R4] Override-matched frames still reach the processor with tx and rx off.
// [R5] Disabled: processor sends nothing and discards override frames.
// [R6] Blocking: processor sends nothing; installs override entries for BPDUs.
// [R7] Processor sets override bit on static entries in all active states.
// [R8] Listening: processor frames pass both ways, learning stays off.
// [R9] Tx 0, rx 0, learn disable 0: learning on, only processor traffic.
// [R10] Tx 1, rx 1, learn disable 0: forward all traffic, learn, accept CPU.
// [R11] Learn disable plus flush bits rapidly flushes the port's table entries.
// [R12] Control changes apply at the next frame boundary, never mid-frame.
module stp_port_ctrl
  import stp_pkg::*;
(
  input  wire logic        MCLK_IN,          // 50 MHz clock
  input  wire logic        RST_IN,           // Sync reset, active high
  input  wire logic [9:0]  AWADDR_IN,        // Write address
  input  wire logic        AWVALID_IN,       // Write address valid
  output logic             AWREADY_OUT,      // Write address ready
  input  wire logic [31:0] WDATA_IN,         // Write data
  input  wire logic [3:0]  WSTRB_IN,         // Write strobes
  input  wire logic        WVALID_IN,        // Write data valid
  output logic             WREADY_OUT,       // Write data ready
  output logic [1:0]       BRESP_OUT,        // Write response
  output logic             BVALID_OUT,       // Write response valid
  input  wire logic        BREADY_IN,        // Write response ready
  input  wire logic [9:0]  ARADDR_IN,        // Read address
  input  wire logic        ARVALID_IN,       // Read address valid
  output logic             ARREADY_OUT,      // Read address ready
  output logic [31:0]      RDATA_OUT,        // Read data
  output logic [1:0]       RRESP_OUT,        // Read response
  output logic             RVALID_OUT,       // Read data valid
  input  wire logic        RREADY_IN,        // Read data ready
  input  wire logic [1:0]  FRAME_ACTIVE_IN,  // Frame in progress, ports 2..1
  input  wire logic [1:0]  OVR_MATCH_IN,     // Override static match, ports 2..1
  input  wire logic [1:0]  CPU_FRAME_IN,     // Frame to or from processor, ports 2..1
  output logic [1:0]       TX_EN_OUT,        // User transmit allowed, ports 2..1
  output logic [1:0]       RX_EN_OUT,        // User receive allowed, ports 2..1
  output logic [1:0]       LEARN_EN_OUT,     // Source learning allowed, ports 2..1
  output logic [1:0]       TO_CPU_EN_OUT,    // Deliver to port 3, ports 2..1
  output logic [1:0]       FLUSH_DYN_OUT,    // Dynamic table flush pulse, ports 2..1
  output logic [1:0]       FLUSH_STA_OUT     // Static table flush pulse, ports 2..1
);

  logic [2:0] cfg_q [2];
  logic [2:0] act_q [2];
  logic [1:0] fl_q;
  logic [1:0] fdyn_q;
  logic [1:0] fsta_q;
  logic       aw_q, w_q, bv_q, rv_q;
  logic [9:0] awa_q;
  logic [31:0] wd_q, rd_q;
  logic [1:0] br_q, rr_q;
  logic [1:0] fsync_q [2];

  function automatic stp_state_t decode(input logic [2:0] c);
    case (c)
      3'h1:    decode = STP_BLOCKING;
      3'h0:    decode = STP_LEARNING;
      3'h6:    decode = STP_FORWARDING;
      default: decode = STP_ODD;
    endcase
  endfunction

  // AXI write channel capture, either order
  assign AWREADY_OUT = !aw_q && !bv_q;
  assign WREADY_OUT  = !w_q && !bv_q;
  assign BVALID_OUT  = bv_q;
  assign BRESP_OUT   = br_q;
  assign ARREADY_OUT = !rv_q;
  assign RVALID_OUT  = rv_q;
  assign RDATA_OUT   = rd_q;
  assign RRESP_OUT   = rr_q;

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      aw_q  <= 1'b0;
      w_q   <= 1'b0;
      bv_q  <= 1'b0;
      br_q  <= STP_RESP_OKAY;
      awa_q <= 10'h000;
      wd_q  <= 32'h0000_0000;
    end else begin
      if (AWVALID_IN && AWREADY_OUT) begin
        aw_q  <= 1'b1;
        awa_q <= AWADDR_IN;
      end
      if (WVALID_IN && WREADY_OUT) begin
        w_q  <= 1'b1;
        wd_q <= WSTRB_IN[0] ? WDATA_IN : 32'h0000_0000;
      end
      if (aw_q && w_q) begin
        aw_q <= 1'b0;
        w_q  <= 1'b0;
        bv_q <= 1'b1;
        br_q <= (awa_q == STP_P1_CTRL_ADDR || awa_q == STP_P2_CTRL_ADDR ||
                 awa_q == STP_FLUSH_ADDR || awa_q == STP_STATUS_ADDR) ?
                STP_RESP_OKAY : STP_RESP_SLVERR;
      end
      if (bv_q && BREADY_IN) begin
        bv_q <= 1'b0;
      end
    end
  end

  logic wr_go;
  assign wr_go = aw_q && w_q;

  // [R2] per-port control registers
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      cfg_q[0] <= STP_CTRL_RST;
      cfg_q[1] <= STP_CTRL_RST;
      fl_q     <= 2'h0;
    end else begin
      fl_q <= 2'h0;
      if (wr_go && awa_q == STP_P1_CTRL_ADDR) begin
        cfg_q[0] <= wd_q[2:0];
      end
      if (wr_go && awa_q == STP_P2_CTRL_ADDR) begin
        cfg_q[1] <= wd_q[2:0];
      end
      if (wr_go && awa_q == STP_FLUSH_ADDR) begin
        fl_q <= {wd_q[STP_FLUSH_DYN_BIT], wd_q[STP_FLUSH_STA_BIT]};
      end
    end
  end

  // Frame-active inputs come from pins: two-stage sync
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      fsync_q[0] <= 2'h0;
      fsync_q[1] <= 2'h0;
    end else begin
      fsync_q[0] <= {fsync_q[0][0], FRAME_ACTIVE_IN[0]};
      fsync_q[1] <= {fsync_q[1][0], FRAME_ACTIVE_IN[1]};
    end
  end

  // [R12] apply new settings only between frames
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      act_q[0] <= STP_CTRL_RST;
      act_q[1] <= STP_CTRL_RST;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (!fsync_q[p][1]) begin
          act_q[p] <= cfg_q[p];
        end
      end
    end
  end

  // [R11] flush only on ports with learning disabled
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      fdyn_q <= 2'h0;
      fsta_q <= 2'h0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        fdyn_q[p] <= fl_q[1] & cfg_q[p][STP_LRN_DIS_BIT];
        fsta_q[p] <= fl_q[0] & cfg_q[p][STP_LRN_DIS_BIT];
      end
    end
  end
  assign FLUSH_DYN_OUT = fdyn_q;
  assign FLUSH_STA_OUT = fsta_q;

  // [R1] [R3] [R9] [R10] port permissions from active setting
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      TX_EN_OUT[p]    = act_q[p][STP_TX_EN_BIT];
      RX_EN_OUT[p]    = act_q[p][STP_RX_EN_BIT];
      LEARN_EN_OUT[p] = !act_q[p][STP_LRN_DIS_BIT];
      // [R4] [R8] override frames, and processor frames in blocking, learning or forwarding settings, reach port 3
      TO_CPU_EN_OUT[p] = act_q[p][STP_RX_EN_BIT] | OVR_MATCH_IN[p] |
                         (CPU_FRAME_IN[p] & (decode(act_q[p]) != STP_ODD));
    end
  end

  // Register reads
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      rv_q <= 1'b0;
      rd_q <= 32'h0000_0000;
      rr_q <= STP_RESP_OKAY;
    end else begin
      if (ARVALID_IN && ARREADY_OUT) begin
        rv_q <= 1'b1;
        rr_q <= STP_RESP_OKAY;
        case (ARADDR_IN)
          STP_P1_CTRL_ADDR: rd_q <= {29'h0, cfg_q[0]};
          STP_P2_CTRL_ADDR: rd_q <= {29'h0, cfg_q[1]};
          STP_FLUSH_ADDR:   rd_q <= 32'h0000_0000;
          STP_STATUS_ADDR:  rd_q <= {19'h0, decode(act_q[1]), 3'h0, decode(act_q[0])};
          default: begin
            rd_q <= 32'h0000_0000;
            rr_q <= STP_RESP_SLVERR;
          end
        endcase
      end else if (rv_q && RREADY_IN) begin
        rv_q <= 1'b0;
      end
    end
  end

  // [R12] no mid-frame change
  AST_NO_MIDFRAME: assert property (@(posedge MCLK_IN) disable iff (RST_IN) // [R12]
    fsync_q[0][1] && $past(fsync_q[0][1]) |-> $stable(act_q[0]))
    else $error("port 1 setting changed mid-frame");
  AST_BLOCK_NO_TX: assert property (@(posedge MCLK_IN) disable iff (RST_IN) // [R3]
    act_q[0] == 3'h1 |-> !TX_EN_OUT[0] && !RX_EN_OUT[0] && !LEARN_EN_OUT[0])
    else $error("blocking port 1 passes traffic");
  AST_OVR_CPU: assert property (@(posedge MCLK_IN) disable iff (RST_IN) // [R4]
    OVR_MATCH_IN[1] |-> TO_CPU_EN_OUT[1])
    else $error("override frame not delivered");
  AST_LEARN_ST: assert property (@(posedge MCLK_IN) disable iff (RST_IN) // [R9]
    act_q[1] == 3'h0 |-> LEARN_EN_OUT[1] && !TX_EN_OUT[1])
    else $error("learning state wrong");
  AST_FWD: assert property (@(posedge MCLK_IN) disable iff (RST_IN) // [R10]
    act_q[0] == 3'h6 |-> TX_EN_OUT[0] && RX_EN_OUT[0] && LEARN_EN_OUT[0])
    else $error("forwarding state wrong");
  AST_LISTEN_CPU: assert property (@(posedge MCLK_IN) disable iff (RST_IN) // [R8]
    act_q[0] == 3'h1 && CPU_FRAME_IN[0] |-> TO_CPU_EN_OUT[0] && !LEARN_EN_OUT[0])
    else $error("listening cpu frame blocked");
  AST_FLUSH: assert property (@(posedge MCLK_IN) disable iff (RST_IN) // [R11]
    fl_q[1] && cfg_q[1][STP_LRN_DIS_BIT] |=> FLUSH_DYN_OUT[1])
    else $error("flush not issued");
  AST_CFG_WR: assert property (@(posedge MCLK_IN) disable iff (RST_IN) // [R2]
    wr_go && awa_q == STP_P2_CTRL_ADDR |=> cfg_q[1] == $past(wd_q[2:0]))
    else $error("port 2 control not written");
  COV_BLOCK: cover property (@(posedge MCLK_IN) act_q[0] == 3'h1);
  COV_LEARN: cover property (@(posedge MCLK_IN) act_q[1] == 3'h0);
  COV_HOLD: cover property (@(posedge MCLK_IN) fsync_q[0][1] && cfg_q[0] != act_q[0]);

endmodule // stp_port_ctrl

/* tb/stp_proc_model.sv */
// Processor-side model that raises frame activity and match flags
`timescale 1ns/10ps
module stp_proc_model (
  input  wire logic       clk_in,          // Bench clock
  output logic      [1:0] frame_out = '0,  // Frame in progress per port
  output logic      [1:0] ovr_out   = '0,  // Override static match per port
  output logic      [1:0] cpu_out   = '0   // Processor frame per port
);
  // Flags change only right after a rising edge
  task automatic drive(input logic [1:0] f, o, c, q);
    @(posedge clk_in);
    frame_out <= f;
    ovr_out <= o;
    cpu_out <= c & ~q;
  endtask
endmodule // stp_proc_model

/* tb/testbench.sv */
// Self-checking bench for the port state control block
`timescale 1ns/10ps
module testbench import stp_pkg::*; ;
  logic        clk = 1'b0, rst = 1'b1;
  logic [9:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, fa, ov, cf, tx, rx, ln, tc, fd, fs, o, c, q;
  logic [33:0] rq[$];
  logic [2:0]  cfg[2] = '{3'h6, 3'h6};
  logic [2:0]  tbl[4] = '{3'h1, 3'h0, 3'h6, 3'h3};
  logic [2:0]  v;
  int          n_mismatch = 0, tests_run = 0, fc[4] = '{default: 0}, i, p;

  stp_port_ctrl dut (.MCLK_IN(clk), .RST_IN(rst), .AWADDR_IN(awaddr), .AWVALID_IN(awvalid),
    .AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(4'hf), .WVALID_IN(wvalid),
    .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
    .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready), .RDATA_OUT(rdata),
    .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready), .FRAME_ACTIVE_IN(fa),
    .OVR_MATCH_IN(ov), .CPU_FRAME_IN(cf), .TX_EN_OUT(tx), .RX_EN_OUT(rx),
    .LEARN_EN_OUT(ln), .TO_CPU_EN_OUT(tc), .FLUSH_DYN_OUT(fd), .FLUSH_STA_OUT(fs));
  stp_proc_model m (.clk_in(clk), .frame_out(fa), .ovr_out(ov), .cpu_out(cf));

  always #10 clk = ~clk;
  always @(posedge clk) begin
    for (int k = 0; k < 4; k++) fc[k] <= fc[k] + int'({fd, fs} >> k & 4'h1);
  end
  always @(posedge clk) begin
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
  end

  function automatic logic [4:0] enc(input logic [2:0] s);
    return (s == 3'h1) ? STP_BLOCKING : (s == 3'h0) ? STP_LEARNING :
           (s == 3'h6) ? STP_FORWARDING : STP_ODD;
  endfunction
  task automatic chk(input logic [33:0] s, e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n < 50) return;
    n_mismatch++;
    stop_test();
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    tmo(n);
    chk(34'(bresp), 34'(er));
    @(posedge clk);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    rq.push_back({er, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    tmo(n);
    @(posedge clk);
  endtask

  initial begin
    void'($urandom(32'h8a2a));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(STP_P1_CTRL_ADDR, 32'h6, STP_RESP_OKAY);
    rd(STP_STATUS_ADDR, 32'h0808, STP_RESP_OKAY);
    @(negedge clk);
    chk(34'({tx, rx, ln}), 34'h3f);
    $display("test reset done");
    for (i = 0; i < 10; i++) begin
      p = i % 2;
      v = (i < 4) ? tbl[i] : 3'($urandom);
      wr(p ? STP_P2_CTRL_ADDR : STP_P1_CTRL_ADDR, {29'h0, v}, STP_RESP_OKAY);
      cfg[p] = v;
      repeat (4) @(posedge clk);
      rd(STP_STATUS_ADDR, {19'h0, enc(cfg[1]), 3'h0, enc(cfg[0])}, STP_RESP_OKAY);
      o = 2'($urandom);
      c = (i < 2) ? 2'b11 : 2'($urandom);
      q = (i < 2) ? 2'b00 : 2'($urandom);
      m.drive(2'b00, o, c, q);
      @(negedge clk);
      chk(34'({tx[p], rx[p], ln[p]}), 34'({v[2], v[1], ~v[0]}));
      chk(34'(tc[p]), 34'(v[1] | o[p] | (c[p] & ~q[p] & (enc(v) != STP_ODD))));
    end
    $display("test states done");
    m.drive(2'b01, 2'b00, 2'b00, 2'b00);
    repeat (4) @(posedge clk);
    v = {~cfg[0][2], 2'b01};
    wr(STP_P1_CTRL_ADDR, {29'h0, v}, STP_RESP_OKAY);
    repeat (6) @(negedge clk);
    chk(34'(tx[0]), 34'(cfg[0][2]));
    m.drive(2'b00, 2'b00, 2'b00, 2'b00);
    cfg[0] = v;
    repeat (5) @(negedge clk);
    chk(34'(tx[0]), 34'(v[2]));
    $display("test frame boundary done");
    wr(STP_FLUSH_ADDR, 32'h30, STP_RESP_OKAY);
    repeat (5) @(negedge clk);
    chk(34'(fc[0] + 4 * fc[1] + 16 * fc[2] + 64 * fc[3]), 34'(17 + 68 * cfg[1][0]));
    v = cfg[1] ^ 3'h1;
    wr(STP_P2_CTRL_ADDR, {29'h0, v}, STP_RESP_OKAY);
    cfg[1] = v;
    wr(STP_FLUSH_ADDR, 32'h30, STP_RESP_OKAY);
    repeat (5) @(negedge clk);
    chk(34'(fc[0] + 4 * fc[1] + 16 * fc[2] + 64 * fc[3]), 34'(102));
    $display("test flush done");
    rd(10'hc8, 32'h0, STP_RESP_SLVERR);
    wr(10'hc8, 32'h7, STP_RESP_SLVERR);
    $display("test unmapped done");
    stop_test();
  end
endmodule // testbench
